// File: fmre_monitor.v
// Purpose: fault monitor turning sensor, memory and fault events into resets or exceptions
// Assumes: all inputs synchronous to clk_sys; sensor inputs high when out of range
// Notes:   forced reset is held for a fixed time; cause register survives it
//
// Contract
// - filter and watch supply, clock and temperature sensor inputs
// - out-of-range parameter forces a reset or raises an exception
// - every ram word carries parity, checked on every read
// - background scan checks all ram in random order when cpu idle
// - ram parity error from read or scan causes a security reset
// - reset returns components to reset values, cause is readable
// - each exception records a readable reason
// - software cannot disable any condition sensor
// - three stack limit copies: user, system and top mode
// - active stack pointer outside its range raises an exception
// - nvm write high voltage checked, stored only as status
// - inverse ecc option raises exception on any detected nvm error; code raises it only for syndromes 1 to 12, not for 13 to 15
// - watchdog inactive until software enables and configures it
// - nvm corrects any single-bit error per byte automatically
// - ram or rom parity error forces a device reset
// - fault injection checks on protected units and fetches
// - light sensors report optical attacks as monitored conditions
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "fmre_defs.vh"
module fmre_monitor #(
  parameter AW      = 8,
  parameter DW      = 32,
  parameter SPW     = 16,
  parameter NFI     = 5,
  parameter FIW     = 8,
  parameter RST_CYC = `FMRE_RSTP_CYC
) (
  // clock and reset
  input  wire                 clk_sys,
  input  wire                 nrst,
  // register port
  input  wire [7:0]           reg_addr,
  input  wire [31:0]          reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [31:0]          reg_rdata,
  // condition sensors
  input  wire                 sens_volt,
  input  wire                 sens_freq,
  input  wire                 sens_temp,
  input  wire                 sens_light,
  // cpu ram port
  input  wire                 ram_req,
  input  wire                 ram_we,
  input  wire [AW-1:0]        ram_addr,
  input  wire [DW-1:0]        ram_wdata,
  output wire [DW-1:0]        ram_rdata,
  // rom read check
  input  wire                 rom_valid,
  input  wire [7:0]           rom_data,
  input  wire                 rom_par,
  // nvm read and write
  input  wire                 nvm_valid,
  input  wire                 nvm_again,
  input  wire [11:0]          nvm_code,
  output reg  [7:0]           nvm_rdata,
  output reg                  nvm_rvalid,
  input  wire                 nvm_wr_seq,
  input  wire                 nvm_hv_ok,
  // stack pointer
  input  wire [1:0]           cpu_mode,
  input  wire                 sp_valid,
  input  wire [SPW-1:0]       sp_value,
  // protected units and fetch
  input  wire [NFI*FIW-1:0]   fi_val,
  input  wire [NFI*FIW-1:0]   fi_chk,
  input  wire                 fetch_valid,
  input  wire [7:0]           fetch_data,
  input  wire [7:0]           fetch_chk,
  // results
  output reg                  force_rst,
  output reg                  exc_req,
  output reg  [3:0]           exc_reason,
  output reg  [3:0]           rst_cause
);

  // ***************
  // shared state
  // ***************
  localparam NB = DW / 8;
  reg  [2:0]     ctrl;
  reg  [23:0]    wdt_load;
  reg  [23:0]    wdt_cnt;
  reg            wdt_run;
  reg  [15:0]    rst_cnt;
  reg  [1:0]     hv_stat;
  wire           in_rst = (rst_cnt != 16'h0000);
  wire           wr_ctrl = reg_wr && (reg_addr == `FMRE_CTRL);

  // ***************
  // sensor filters
  // ***************
  // a short glitch is not a fault: level must persist the filter time
  wire [3:0] sens_raw = {sens_light, sens_temp, sens_freq, sens_volt};
  wire [3:0] sens_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_filt
      reg [3:0] fcnt;
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          fcnt <= 4'h0;
        end else if (!sens_raw[gi]) begin
          fcnt <= 4'h0;
        end else if (fcnt != `FMRE_FILT_CYC) begin
          fcnt <= fcnt + 4'h1;
        end
      end
      // no enable bit exists, so software can never mask a sensor
      assign sens_hit[gi] = (fcnt == `FMRE_FILT_CYC);
    end
  endgenerate

  // ***************
  // ram with parity and scan
  // ***************
  reg  [7:0]     scan_lfsr;
  reg            rd_pend;
  wire [DW-1:0]  ram_q;
  wire [NB-1:0]  ram_qp;
  wire [NB-1:0]  wpar;
  wire [NB-1:0]  rchk;
  generate
    for (gi = 0; gi < NB; gi = gi + 1) begin : g_par
      assign wpar[gi] = ^ram_wdata[gi*8 +: 8];
      assign rchk[gi] = (^ram_q[gi*8 +: 8]) ^ ram_qp[gi];
    end
  endgenerate
  // scan steals only idle cycles so cpu access never waits
  wire           scan_go = !ram_req && !in_rst;
  wire [AW-1:0]  mem_addr = ram_req ? ram_addr : scan_lfsr[AW-1:0];
  wire           mem_en = ram_req || scan_go;
  wire           mem_we = ram_req && ram_we;
  assign ram_rdata = ram_q;
  fmre_ram #(
    .AW    (AW),
    .DW    (DW)
  ) u_ram (
    .clk_sys (clk_sys),
    .en      (mem_en),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (ram_wdata),
    .wpar    (wpar),
    .rdata   (ram_q),
    .rpar    (ram_qp)
  );
  // de bruijn step so address zero is visited as well
  wire lfsr_fb = scan_lfsr[7] ^ scan_lfsr[5] ^ scan_lfsr[4] ^ scan_lfsr[3]
                 ^ (scan_lfsr[6:0] == 7'h00);
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scan_lfsr <= 8'h01;
      rd_pend   <= 1'b0;
    end else begin
      rd_pend <= mem_en && !mem_we;
      if (scan_go) begin
        scan_lfsr <= {scan_lfsr[6:0], lfsr_fb};
      end
    end
  end
  wire ram_err = rd_pend && (rchk != {NB{1'b0}});
  wire rom_err = rom_valid && ((^rom_data) != rom_par);

  // ***************
  // nvm correction
  // ***************
  // hamming 12,8: code bit p-1 holds position p, checks at 1,2,4,8
  function [11:0] fmre_fix;
    input [11:0] c;
    reg   [3:0]  s;
    reg   [11:0] o;
    integer      k;
    begin
      s = 4'h0;
      o = c;
      for (k = 1; k <= 12; k = k + 1) begin
        if (c[k-1]) begin
          s = s ^ k[3:0];
        end
      end
      if (s != 4'h0 && s <= 4'hc) begin
        o[s-4'h1] = ~c[s-4'h1];
      end
      fmre_fix = o;
    end
  endfunction
  wire [11:0] nvm_fixed = fmre_fix(nvm_code);
  wire [7:0]  nvm_byte = {nvm_fixed[11:8], nvm_fixed[6:4], nvm_fixed[2]};
  wire        nvm_bad = (nvm_fixed != nvm_code);
  reg  [7:0]  nvm_last;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      nvm_rdata  <= 8'h00;
      nvm_rvalid <= 1'b0;
      nvm_last   <= 8'h00;
    end else begin
      nvm_rvalid <= nvm_valid;
      if (nvm_valid) begin
        nvm_rdata <= nvm_byte;
        nvm_last  <= nvm_byte;
      end
    end
  end
  wire ecc_exc = nvm_valid && nvm_bad && ctrl[`FMRE_CTRL_EINV];
  wire dbl_exc = nvm_valid && nvm_again && ctrl[`FMRE_CTRL_DBL]
                 && (nvm_byte != nvm_last);

  // ***************
  // stack limits
  // ***************
  wire [2:0] sp_out;
  wire [SPW-1:0] sp_lo_q [0:2];
  wire [SPW-1:0] sp_hi_q [0:2];
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sp
      reg [SPW-1:0] lo;
      reg [SPW-1:0] hi;
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          lo <= {SPW{1'b0}};
          hi <= {SPW{1'b1}};
        end else if (in_rst) begin
          lo <= {SPW{1'b0}};
          hi <= {SPW{1'b1}};
        end else if (reg_wr && reg_addr == `FMRE_SP_BASE + gi * 8) begin
          lo <= reg_wdata[SPW-1:0];
        end else if (reg_wr && reg_addr == `FMRE_SP_BASE + gi * 8 + 4) begin
          hi <= reg_wdata[SPW-1:0];
        end
      end
      assign sp_lo_q[gi] = lo;
      assign sp_hi_q[gi] = hi;
      assign sp_out[gi] = (cpu_mode == gi) && (sp_value < lo || sp_value > hi);
    end
  endgenerate
  wire sp_exc = sp_valid && (sp_out != 3'b000);

  // ***************
  // fault injection checks
  // ***************
  wire [NFI-1:0] fi_err;
  generate
    for (gi = 0; gi < NFI; gi = gi + 1) begin : g_fi
      assign fi_err[gi] = (fi_val[gi*FIW +: FIW] != ~fi_chk[gi*FIW +: FIW]);
    end
  endgenerate
  wire fault = (fi_err != {NFI{1'b0}})
               || (fetch_valid && fetch_data != ~fetch_chk);

  // ***************
  // watchdog
  // ***************
  wire wdt_expire = wdt_run && (wdt_cnt == 24'h000000);
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wdt_cnt <= `FMRE_WDT_RST;
      wdt_run <= 1'b0;
    end else if (in_rst || !ctrl[`FMRE_CTRL_WDT]) begin
      wdt_cnt <= wdt_load;
      wdt_run <= 1'b0;
    end else if (!wdt_run || (reg_wr && reg_addr == `FMRE_WDT_KICK)) begin
      wdt_cnt <= wdt_load;
      wdt_run <= 1'b1;
    end else if (wdt_cnt != 24'h000000) begin
      wdt_cnt <= wdt_cnt - 24'h000001;
    end
  end

  // ***************
  // reset and exception decision
  // ***************
  reg       rst_ev;
  reg [3:0] next_cause;
  always @* begin
    rst_ev     = 1'b1;
    next_cause = `FMRE_RC_POWER;
    if (sens_hit[0]) begin
      next_cause = `FMRE_RC_VOLT;
    end else if (sens_hit[1]) begin
      next_cause = `FMRE_RC_FREQ;
    end else if (sens_hit[2]) begin
      next_cause = `FMRE_RC_TEMP;
    end else if (ram_err) begin
      next_cause = `FMRE_RC_RAMPAR;
    end else if (rom_err) begin
      next_cause = `FMRE_RC_ROMPAR;
    end else if (fault) begin
      next_cause = `FMRE_RC_FAULT;
    end else if (wdt_expire) begin
      next_cause = `FMRE_RC_WDT;
    end else begin
      rst_ev = 1'b0;
    end
  end

  reg       exc_ev;
  reg [3:0] next_reason;
  always @* begin
    exc_ev      = 1'b1;
    next_reason = `FMRE_EX_NONE;
    if (sens_hit[3]) begin
      next_reason = `FMRE_EX_LIGHT;
    end else if (sp_exc) begin
      next_reason = `FMRE_EX_STACK;
    end else if (ecc_exc) begin
      next_reason = `FMRE_EX_ECC;
    end else if (dbl_exc) begin
      next_reason = `FMRE_EX_DBLRD;
    end else begin
      exc_ev = 1'b0;
    end
  end

  // a reset outranks an exception in the same cycle
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_cnt    <= 16'h0000;
      force_rst  <= 1'b0;
      rst_cause  <= `FMRE_RC_POWER;
      exc_req    <= 1'b0;
      exc_reason <= `FMRE_EX_NONE;
    end else begin
      exc_req <= 1'b0;
      if (in_rst) begin
        rst_cnt   <= rst_cnt - 16'h0001;
        force_rst <= (rst_cnt != 16'h0001);
      end else if (rst_ev) begin
        rst_cnt   <= RST_CYC[15:0];
        force_rst <= 1'b1;
        rst_cause <= next_cause;
      end else if (exc_ev) begin
        exc_req    <= 1'b1;
        exc_reason <= next_reason;
      end
    end
  end

  // ***************
  // registers
  // ***************
  // forced reset clears control state but not the cause
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl     <= `FMRE_CTRL_RST;
      wdt_load <= `FMRE_WDT_RST;
      hv_stat  <= 2'b00;
    end else if (in_rst) begin
      ctrl     <= `FMRE_CTRL_RST;
      wdt_load <= `FMRE_WDT_RST;
      hv_stat  <= 2'b00;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `FMRE_WDT_LOAD) begin
        wdt_load <= reg_wdata[23:0];
      end
      if (nvm_wr_seq) begin
        hv_stat <= {1'b1, nvm_hv_ok};
      end
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else begin
      case (reg_addr)
        `FMRE_CTRL:       reg_rdata <= {29'h0, ctrl};
        `FMRE_WDT_LOAD:   reg_rdata <= {8'h00, wdt_load};
        `FMRE_RST_CAUSE:  reg_rdata <= {28'h0, rst_cause};
        `FMRE_EXC_REASON: reg_rdata <= {28'h0, exc_reason};
        `FMRE_NVM_HV:     reg_rdata <= {30'h0, hv_stat};
        `FMRE_SENSE:      reg_rdata <= {28'h0, sens_hit};
        8'h20:            reg_rdata <= {{(32-SPW){1'b0}}, sp_lo_q[0]};
        8'h24:            reg_rdata <= {{(32-SPW){1'b0}}, sp_hi_q[0]};
        8'h28:            reg_rdata <= {{(32-SPW){1'b0}}, sp_lo_q[1]};
        8'h2c:            reg_rdata <= {{(32-SPW){1'b0}}, sp_hi_q[1]};
        8'h30:            reg_rdata <= {{(32-SPW){1'b0}}, sp_lo_q[2]};
        8'h34:            reg_rdata <= {{(32-SPW){1'b0}}, sp_hi_q[2]};
        default:          reg_rdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// File: fmre_defs.vh
// Purpose: constants of the fault monitor, reset and exception unit
// Assumes: 125 MHz system clock, 8 ns period
// Notes:   byte offsets on an 8-bit register address
`ifndef FMRE_DEFS_VH
`define FMRE_DEFS_VH

// ***************
// timing
// ***************
`define FMRE_CLK_NS      8
`define FMRE_FILT_NS     40
`define FMRE_FILT_CYC    ((`FMRE_FILT_NS + `FMRE_CLK_NS - 1) / `FMRE_CLK_NS)
`define FMRE_RSTP_NS     1000
`define FMRE_RSTP_CYC    (`FMRE_RSTP_NS / `FMRE_CLK_NS)
`define FMRE_WDT_RST     24'h0f4240

// ***************
// register offsets
// ***************
`define FMRE_CTRL        8'h00
`define FMRE_WDT_LOAD    8'h04
`define FMRE_WDT_KICK    8'h08
`define FMRE_RST_CAUSE   8'h0c
`define FMRE_EXC_REASON  8'h10
`define FMRE_NVM_HV      8'h14
`define FMRE_SENSE       8'h18
`define FMRE_SP_BASE     8'h20

// ***************
// control fields
// ***************
`define FMRE_CTRL_WDT    0
`define FMRE_CTRL_DBL    1
`define FMRE_CTRL_EINV   2
`define FMRE_CTRL_RST    3'h0

// ***************
// reset causes
// ***************
`define FMRE_RC_POWER    4'h0
`define FMRE_RC_VOLT     4'h1
`define FMRE_RC_FREQ     4'h2
`define FMRE_RC_TEMP     4'h3
`define FMRE_RC_RAMPAR   4'h4
`define FMRE_RC_ROMPAR   4'h5
`define FMRE_RC_FAULT    4'h6
`define FMRE_RC_WDT      4'h7

// ***************
// exception reasons
// ***************
`define FMRE_EX_NONE     4'h0
`define FMRE_EX_LIGHT    4'h1
`define FMRE_EX_STACK    4'h2
`define FMRE_EX_ECC      4'h3
`define FMRE_EX_DBLRD    4'h4

`endif

// File: fmre_ram.v
// Purpose: ram array with per-byte parity bits
// Assumes: single port, one access per cycle
// Notes:   read data and parity come out of registers
`timescale 1ns/1ns
module fmre_ram #(
  parameter AW = 8,
  parameter DW = 32
) (
  // clock
  input  wire              clk_sys,
  // access
  input  wire              en,
  input  wire              we,
  input  wire [AW-1:0]     addr,
  input  wire [DW-1:0]     wdata,
  input  wire [DW/8-1:0]   wpar,
  // read result
  output reg  [DW-1:0]     rdata,
  output reg  [DW/8-1:0]   rpar
);

  reg [DW+DW/8-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_sys) begin
    if (en && we) begin
      mem[addr] <= {wpar, wdata};
    end
    if (en && !we) begin
      {rpar, rdata} <= mem[addr];
    end
  end

endmodule

// File: fmre_monitor_sva.sv
// Purpose: port assertions for the fault monitor
// Assumes: one clock, async active-low reset
// Notes:   filter depth five edges, forced reset RST_CYC cycles
`timescale 1ns/1ns
`include "fmre_defs.vh"
module fmre_monitor_sva #(
  parameter RST_CYC = 125
) (
  // clock and reset
  input wire        clk_sys,
  input wire        nrst,
  // watched inputs
  input wire        reg_rd,
  input wire        sens_volt,
  input wire        sens_light,
  input wire        rom_valid,
  input wire [7:0]  rom_data,
  input wire        rom_par,
  input wire        nvm_valid,
  input wire        fetch_valid,
  input wire [7:0]  fetch_data,
  input wire [7:0]  fetch_chk,
  // watched outputs
  input wire [31:0] reg_rdata,
  input wire        nvm_rvalid,
  input wire        force_rst,
  input wire        exc_req,
  input wire [3:0]  exc_reason,
  input wire [3:0]  rst_cause
);
  // ***************
  // helper
  // ***************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // a counter, since the pulse is far longer than a repetition may be
  reg [15:0] hi_cnt;
  always @(posedge clk_sys or negedge nrst)
    if (!nrst)
      hi_cnt <= 16'h0;
    else
      hi_cnt <= force_rst ? hi_cnt + 16'h1 : 16'h0;
  // ***************
  // checks
  // ***************
  a_volt_forces_rst: assert property ((sens_volt && !force_rst)[*5] |-> ##[1:2] force_rst)
    else $error("volt out of range did not force reset");
  a_rst_length: assert property ($fell(force_rst) |-> hi_cnt == RST_CYC)
    else $error("forced reset length wrong");
  a_volt_cause: assert property ($rose(force_rst) && rst_cause == `FMRE_RC_VOLT |-> $past(sens_volt))
    else $error("volt cause without volt sensor");
  a_cause_hold: assert property (!$rose(force_rst) |-> $stable(rst_cause))
    else $error("reset cause changed without reset");
  a_reason_hold: assert property (!exc_req && !force_rst |-> $stable(exc_reason))
    else $error("exception reason changed without exception");
  a_light_exc: assert property ((sens_light && !force_rst)[*6] |=> exc_req && exc_reason == `FMRE_EX_LIGHT)
    else $error("light attack raised no exception");
  a_rom_parity: assert property (rom_valid && (rom_par != ^rom_data) && !force_rst |=> force_rst)
    else $error("rom parity error did not force reset");
  a_fetch_fault: assert property (fetch_valid && fetch_chk != ~fetch_data && !force_rst |=> force_rst)
    else $error("fetch check failure did not force reset");
  a_nvm_answer: assert property (nvm_valid && !force_rst |=> nvm_rvalid)
    else $error("nvm read not answered next cycle");
  a_read_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read answer cycle");
  c_forced: cover property ($rose(force_rst));
  c_exc: cover property (exc_req && exc_reason == `FMRE_EX_STACK);
  c_nvm_exc: cover property (nvm_rvalid && exc_req);
endmodule
bind fmre_monitor fmre_monitor_sva #(.RST_CYC(RST_CYC)) u_sva (
  .clk_sys(clk_sys), .nrst(nrst), .reg_rd(reg_rd), .sens_volt(sens_volt),
  .sens_light(sens_light), .rom_valid(rom_valid), .rom_data(rom_data), .rom_par(rom_par),
  .nvm_valid(nvm_valid), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
  .fetch_chk(fetch_chk), .reg_rdata(reg_rdata), .nvm_rvalid(nvm_rvalid),
  .force_rst(force_rst), .exc_req(exc_req), .exc_reason(exc_reason), .rst_cause(rst_cause)
);

// File: fmre_cpu_model.sv
// Purpose: cpu side model driving the ram port
// Assumes: read data stands in the cycle after a read
// Notes:   idle gap between phases leaves room for the scan
`timescale 1ns/1ns
module fmre_cpu_model (
  // clock and control
  input  wire        clk_sys,
  input  wire        go,
  output reg         done,
  output integer     errs,
  // ram port
  output reg         ram_req,
  output reg         ram_we,
  output reg  [7:0]  ram_addr,
  output reg  [31:0] ram_wdata,
  input  wire [31:0] ram_rdata
);
  // ***************
  // traffic
  // ***************
  integer    seed;
  reg [7:0]  a;
  reg [31:0] d;
  reg [31:0] mem [0:255];
  reg [7:0]  aq [$];
  initial begin
    seed = 96668;
    errs = 0;
    {done, ram_req, ram_we, ram_addr, ram_wdata} = 43'h0;
    wait (go === 1'b1);
    repeat (16) begin
      @(posedge clk_sys);
      a = $random(seed);
      d = $random(seed);
      mem[a] = d;
      aq.push_back(a);
      ram_req <= 1'b1;
      ram_we <= 1'b1;
      ram_addr <= a;
      ram_wdata <= d;
    end
    @(posedge clk_sys);
    ram_req <= 1'b0;
    ram_we <= 1'b0;
    ram_wdata <= ~d;
    repeat (20) @(posedge clk_sys); // idle cycles for the scan
    while (aq.size() > 0) begin
      a = aq.pop_front();
      @(posedge clk_sys);
      ram_req <= 1'b1;
      ram_addr <= a;
      @(posedge clk_sys);
      ram_req <= 1'b0;
      #1;
      if (ram_rdata !== mem[a]) errs = errs + 1;
    end
    done = 1'b1;
  end
endmodule

// File: fmre_monitor_tb.sv
// Purpose: self-checking bench for the fault monitor
// Assumes: forced reset shortened to 4 cycles
// Notes:   ram traffic comes from the cpu model
`timescale 1ns/1ns
`include "fmre_defs.vh"
module fmre_monitor_tb;
  // ***************
  // signals
  // ***************
  reg  clk_sys, nrst, reg_wr, reg_rd, rom_valid, rom_par, nvm_valid, nvm_again;
  reg  nvm_wr_seq, nvm_hv_ok, sp_valid, fetch_valid, go;
  reg  [7:0]  reg_addr, rom_data, fetch_data, fetch_chk, d, prev;
  reg  [31:0] reg_wdata;
  reg  [3:0]  sens, r;
  reg  [11:0] nvm_code;
  reg  [1:0]  cpu_mode;
  reg  [15:0] sp_value;
  reg  [39:0] fi_val, fi_bad;
  wire [31:0] reg_rdata, ram_wdata, ram_rdata;
  wire [7:0]  ram_addr, nvm_rdata;
  wire [3:0]  exc_reason, rst_cause;
  wire        ram_req, ram_we, nvm_rvalid, force_rst, exc_req, done;
  integer     errs, seed, i, e, x, lo, off, ctl;
  integer     compares = 0, miscompares = 0, cyc = 0, n_ev = 0;
  fmre_monitor #(.RST_CYC(4)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sens_volt(sens[0]),
    .sens_freq(sens[1]), .sens_temp(sens[2]), .sens_light(sens[3]), .ram_req(ram_req),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
    .rom_valid(rom_valid), .rom_data(rom_data), .rom_par(rom_par), .nvm_valid(nvm_valid),
    .nvm_again(nvm_again), .nvm_code(nvm_code), .nvm_rdata(nvm_rdata),
    .nvm_rvalid(nvm_rvalid), .nvm_wr_seq(nvm_wr_seq), .nvm_hv_ok(nvm_hv_ok),
    .cpu_mode(cpu_mode), .sp_valid(sp_valid), .sp_value(sp_value), .fi_val(fi_val),
    .fi_chk(~fi_val ^ fi_bad), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
    .fetch_chk(fetch_chk), .force_rst(force_rst), .exc_req(exc_req),
    .exc_reason(exc_reason), .rst_cause(rst_cause));
  fmre_cpu_model cpu (.clk_sys(clk_sys), .go(go), .done(done), .errs(errs),
    .ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata));
  // ***************
  // tasks
  // ***************
  task finish_test;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input string name, input [31:0] ex, input [31:0] got);
    begin
      compares = compares + 1;
      if (got !== ex) begin
        miscompares = miscompares + 1;
        $display("[ERR] %s expected %h seen %h", name, ex, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] ex);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", ex, reg_rdata);
    end
  endtask
  task quiet(input integer n);
    integer n0;
    begin
      n0 = n_ev;
      repeat (n) @(posedge clk_sys);
      chk("events", n0, n_ev);
    end
  endtask
  // cause kept, control registers back at reset values
  task expect_rst(input [3:0] code);
    integer k;
    begin
      k = 0;
      #1;
      while (force_rst !== 1'b1 && k < 40) begin
        @(posedge clk_sys);
        #1 k = k + 1;
      end
      sens <= 4'h0;
      chk("force_rst", 1, force_rst);
      chk("rst_cause", code, rst_cause);
      while (force_rst === 1'b1) begin
        @(posedge clk_sys);
        #1;
      end
      rd(`FMRE_RST_CAUSE, code);
      rd(`FMRE_CTRL, 32'h0);
      rd(`FMRE_WDT_LOAD, `FMRE_WDT_RST);
    end
  endtask
  function [11:0] ham(input [7:0] v);
    reg [11:0] c;
    begin
      c = {v[7:4], 1'b0, v[3:1], 1'b0, v[0], 2'b00};
      c[0] = ^(c & 12'h554);
      c[1] = ^(c & 12'h664);
      c[3] = ^(c & 12'h870);
      c[7] = ^(c & 12'hf00);
      ham = c;
    end
  endfunction
  // ***************
  // run
  // ***************
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // counted off the edge so quiet never races the design's own update
  always @(negedge clk_sys) begin
    if (force_rst === 1'b1 || exc_req === 1'b1) n_ev = n_ev + 1;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end
  initial begin
    seed = 96668;
    {nrst, reg_wr, reg_rd, rom_valid, rom_par, nvm_valid, nvm_again, nvm_wr_seq} = 8'h0;
    {nvm_hv_ok, sp_valid, fetch_valid, go, reg_addr, rom_data, fetch_data} = 28'h0;
    {fetch_chk, prev, reg_wdata, sens, nvm_code, cpu_mode, sp_value, fi_bad} = 122'h0;
    fi_val = {$random(seed), $random(seed)};
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(`FMRE_RST_CAUSE, `FMRE_RC_POWER);
    rd(`FMRE_EXC_REASON, `FMRE_EX_NONE);
    rd(`FMRE_SP_BASE + 8'h14, 32'hffff);
    rd(8'h3c, 32'h0);
    go <= 1'b1;
    wait (done === 1'b1);
    chk("ram_errs", 0, errs);
    quiet(300);
    wr(`FMRE_SENSE, 32'h0);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`FMRE_CTRL, 32'hffffffff);
      @(posedge clk_sys);
      sens[i] <= 1'b1;
      expect_rst(i[3:0] + 4'h1);
    end
    @(posedge clk_sys);
    sens[3] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 chk("exc_req", 1, exc_req);
    rd(`FMRE_SENSE, 32'h8);
    sens[3] <= 1'b0;
    rd(`FMRE_EXC_REASON, `FMRE_EX_LIGHT);
    for (i = 0; i < 16; i = i + 1) begin
      ctl = i / 2;
      if (i % 4 == 0) wr(`FMRE_CTRL, ctl);
      e = i % 2 ? 12 : {$random(seed)} % 13;
      d = (i % 2 && $random(seed) % 2) ? prev : $random(seed);
      x = (ctl[2] && e < 12) || (ctl[1] && i % 2 && d != prev);
      r = (ctl[2] && e < 12) ? `FMRE_EX_ECC : `FMRE_EX_DBLRD;
      @(posedge clk_sys);
      nvm_valid <= 1'b1;
      nvm_again <= i % 2;
      nvm_code <= ham(d) ^ (12'h1 << e);
      @(posedge clk_sys);
      nvm_valid <= 1'b0;
      #1 chk("nvm_rvalid", 1, nvm_rvalid);
      chk("nvm_rdata", d, nvm_rdata);
      chk("nvm_exc", x, exc_req);
      if (x) chk("exc_reason", r, exc_reason);
      prev = d;
    end
    for (i = 0; i < 3; i = i + 1) begin
      wr(`FMRE_SP_BASE + 8 * i, 256 * (i + 1));
      wr(`FMRE_SP_BASE + 8 * i + 4, 256 * (i + 1) + 255);
    end
    for (i = 0; i < 16; i = i + 1) begin
      lo = 256 * (i / 4 + 1);
      off = (i % 4 == 0) ? -1 : (i % 4 == 1) ? 0 : 253 + i % 4;
      x = i < 12 && (off < 0 || off > 255);
      @(posedge clk_sys);
      cpu_mode <= i / 4;
      sp_value <= lo + off;
      sp_valid <= 1'b1;
      @(posedge clk_sys);
      sp_valid <= 1'b0;
      #1 chk("sp_exc", x, exc_req);
      if (x) chk("exc_reason", `FMRE_EX_STACK, exc_reason);
    end
    @(posedge clk_sys);
    nvm_wr_seq <= 1'b1;
    quiet(4);
    nvm_wr_seq <= 1'b0;
    rd(`FMRE_NVM_HV, 32'h2);
    @(posedge clk_sys);
    rom_valid <= 1'b1;
    rom_data <= 8'ha5;
    rom_par <= 1'b1;
    @(posedge clk_sys);
    rom_valid <= 1'b0;
    expect_rst(`FMRE_RC_ROMPAR);
    @(posedge clk_sys);
    fetch_valid <= 1'b1;
    fetch_data <= 8'h3c;
    fetch_chk <= 8'h3c;
    @(posedge clk_sys);
    fetch_valid <= 1'b0;
    expect_rst(`FMRE_RC_FAULT);
    @(posedge clk_sys);
    fi_bad <= 40'h1 << 17;
    @(posedge clk_sys);
    fi_bad <= 40'h0;
    expect_rst(`FMRE_RC_FAULT);
    wr(`FMRE_WDT_LOAD, 32'd20);
    quiet(40);
    wr(`FMRE_CTRL, 32'h1);
    quiet(15);
    wr(`FMRE_WDT_KICK, 32'h0);
    quiet(15);
    expect_rst(`FMRE_RC_WDT);
    finish_test;
  end
endmodule
